/* inc/strap_defaults_consts.vh */
/*
 * constants for the port 1 strap default loader: register offsets,
 * field positions and mode encodings.
 * assumes: included by src/port1_strap_defaults.v only.
 */
`ifndef STRAP_DEFAULTS_CONSTS_VH
`define STRAP_DEFAULTS_CONSTS_VH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define OFS_BASIC_CTRL   4'h0
`define OFS_AUTONEG_ADV  4'h1
`define OFS_MODE_SELECT  4'h2
`define OFS_MANUAL_PAUSE 4'h3
`define OFS_PAUSE_STATUS 4'h4

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define BIT_RATE_SEL     13
`define BIT_AUTONEG_EN   12
`define BIT_HALFFULL     8
`define BIT_ADV_PAUSE    10
`define BIT_ADV_100FD    8
`define BIT_ADV_100HD    7
`define BIT_ADV_10FD     6
`define BIT_ADV_10HD     5
`define BIT_SEL_FIELD_LO 0
`define BIT_SEL_FIELD_HI 4
`define MODE_LO          5
`define MODE_HI          7
`define BIT_BP_EN        3
`define BIT_MANUAL_SEL   2
`define BIT_TX_PAUSE     1
`define BIT_RX_PAUSE     0

// ------------------------------------------------------------------
// reset values and mode encodings
// ------------------------------------------------------------------
`define SEL_FIELD_8023   5'h01
`define MODE_10HD        3'h0
`define MODE_10FD        3'h1
`define MODE_100HD       3'h2
`define MODE_100FD       3'h3
`define MODE_ALL_AN      3'h7
`define ZERO16           16'h0000

`endif

/* src/port1_strap_defaults.v */
/*
 * port 1 strap default loader: turns the speed, duplex, backpressure,
 * pause and manual pause select straps into reset defaults of the
 * port 1 control, advertisement, mode and manual pause registers,
 * which software may then overwrite, and resolves the pause enables.
 * assumes: straps are stable and synchronous to clk_i around reset
 * release; the register port is a simple one-cycle strobe slave.
 * timing: the first edge after reset release loads the registers,
 * and the second edge shows them on the status outputs. A write that
 * lands on the load edge is lost and a read there sees pre-load values, so callers wait one edge.
 * software writes replace whole register words; offset 4 is a read
 * only view of the resolved pause enables and ignores writes.
 */
`timescale 1ns/1ps
`include "strap_defaults_consts.vh"

module port1_strap_defaults
(
    input  wire        clk_i,
    input  wire        rst_n_i,
    input  wire        speed_default_i,
    input  wire        duplex_default_i,
    input  wire        autoneg_default_i,
    input  wire        port1_backpressure_default_input_i,
    input  wire        port1_pause_default_input_i,
    input  wire        port1_manual_pause_select_input_i,
    input  wire        an_pause_tx_i,
    input  wire        an_pause_rx_i,
    input  wire [3:0]  addr_i,
    input  wire [15:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [15:0] rdata_o,
    output reg         rate_select_low_bit_o,
    output reg         halffull_mode_bit_o,
    output reg         port1_backpressure_bit_o,
    output reg         pause_tx_en_o,
    output reg         pause_rx_en_o
);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    reg  [15:0] basic_ctrl_reg;       // port1 basic control
    reg  [15:0] basic_ctrl_next;
    reg  [15:0] autoneg_advert_reg;   // advertisement
    reg  [15:0] autoneg_advert_next;
    reg  [15:0] mode_select_reg;      // special modes
    reg  [15:0] mode_select_next;
    reg  [3:0]  manual_pause_reg;     // bp, manual sel, tx, rx
    reg  [3:0]  manual_pause_next;
    reg         load_pending_reg;     // one load after reset release
    reg  [15:0] rdata_next;
    reg  [2:0]  mode_dflt;            // strap derived mode
    wire        man_sel;              // manual pause select bit
    wire        tx_res;               // resolved transmit pause enable
    wire        rx_res;               // resolved receive pause enable

    // ------------------------------------------------------------------
    // strap derived mode field
    // ------------------------------------------------------------------
    // combine autoneg, speed and duplex into the mode code
    // autoneg strap wins: all capabilities with negotiation on
    always @*
    begin
        if (autoneg_default_i)
            mode_dflt = `MODE_ALL_AN;
        // fixed mode: code follows speed then duplex strap
        else
            mode_dflt = {1'b0, speed_default_i,
                         duplex_default_i};
    end

    // ------------------------------------------------------------------
    // pause resolution
    // ------------------------------------------------------------------
    // the select comes from the register, not the strap, so
    // software can switch between manual and negotiated pause
    assign man_sel = manual_pause_reg[`BIT_MANUAL_SEL];
    // manual select picks register enables over autoneg result
    assign tx_res  = man_sel ? manual_pause_reg[`BIT_TX_PAUSE]
                             : an_pause_tx_i;
    assign rx_res  = man_sel ? manual_pause_reg[`BIT_RX_PAUSE]
                             : an_pause_rx_i;

    // ------------------------------------------------------------------
    // next state: strap load then software writes
    // ------------------------------------------------------------------
    // the load has priority over a write, so a write on the load
    // edge is dropped rather than half merged with the defaults
    always @*
    begin
        // hold every register unless loaded or written
        basic_ctrl_next     = basic_ctrl_reg;
        autoneg_advert_next = autoneg_advert_reg;
        mode_select_next    = mode_select_reg;
        manual_pause_next   = manual_pause_reg;
        if (load_pending_reg)
        begin
            // straps act only in the first cycle after reset
            basic_ctrl_next = `ZERO16;
            basic_ctrl_next[`BIT_RATE_SEL] =
                speed_default_i;
            basic_ctrl_next[`BIT_HALFFULL] =
                duplex_default_i;
            basic_ctrl_next[`BIT_AUTONEG_EN] = autoneg_default_i;
            // advertisement: selector field plus capability bits
            autoneg_advert_next = `ZERO16;
            autoneg_advert_next[`BIT_SEL_FIELD_HI:`BIT_SEL_FIELD_LO] =
                `SEL_FIELD_8023;
            autoneg_advert_next[`BIT_ADV_100FD] = 1'b1;
            autoneg_advert_next[`BIT_ADV_100HD] = 1'b1;
            // 10 full under the autoneg strap, or when slow speed allows full duplex
            autoneg_advert_next[`BIT_ADV_10FD] = autoneg_default_i |
                (~speed_default_i & duplex_default_i);
            // 10 half whenever the slow speed is strapped
            autoneg_advert_next[`BIT_ADV_10HD] = autoneg_default_i |
                ~speed_default_i;
            // symmetric pause advertised only under negotiated pause
            autoneg_advert_next[`BIT_ADV_PAUSE] =
                ~port1_manual_pause_select_input_i;
            // mode field alone in the special modes word
            mode_select_next = `ZERO16;
            mode_select_next[`MODE_HI:`MODE_LO] = mode_dflt;
            // manual pause word: backpressure, select, tx, rx
            manual_pause_next[`BIT_BP_EN] =
                port1_backpressure_default_input_i;
            manual_pause_next[`BIT_MANUAL_SEL] =
                port1_manual_pause_select_input_i;
            manual_pause_next[`BIT_TX_PAUSE] =
                port1_pause_default_input_i;
            manual_pause_next[`BIT_RX_PAUSE] =
                port1_pause_default_input_i;
        end
        else if (wr_i)
        begin
            // software owns the fields after the load
            case (addr_i)
                `OFS_BASIC_CTRL:   basic_ctrl_next     = wdata_i;
                `OFS_AUTONEG_ADV:  autoneg_advert_next = wdata_i;
                `OFS_MODE_SELECT:  mode_select_next    = wdata_i;
                `OFS_MANUAL_PAUSE: manual_pause_next   = wdata_i[3:0];
                // status and unmapped offsets take no writes
                default:           ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    // unmapped offsets read as zero
    // idle cycles also return zero so read data stands one cycle
    always @*
    begin
        rdata_next = `ZERO16;
        if (rd_i)
        begin
            case (addr_i)
                `OFS_BASIC_CTRL:   rdata_next = basic_ctrl_reg;
                `OFS_AUTONEG_ADV:  rdata_next = autoneg_advert_reg;
                `OFS_MODE_SELECT:  rdata_next = mode_select_reg;
                `OFS_MANUAL_PAUSE: rdata_next = {12'h000, manual_pause_reg};
                `OFS_PAUSE_STATUS: rdata_next = {14'h0000, tx_res, rx_res};
                default:           rdata_next = `ZERO16;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state and output flops
    // ------------------------------------------------------------------
    // reset holds constants; straps land one edge after release
    // status outputs trail their register fields, or the negotiated pause inputs, by one edge
    always @(posedge clk_i or negedge rst_n_i)
    begin
        // reset: arm the strap load, clear everything else
        if (!rst_n_i)
        begin
            load_pending_reg         <= 1'b1;
            basic_ctrl_reg           <= `ZERO16;
            autoneg_advert_reg       <= `ZERO16;
            mode_select_reg          <= `ZERO16;
            manual_pause_reg         <= 4'h0;
            rdata_o                  <= `ZERO16;
            rate_select_low_bit_o    <= 1'b0;
            halffull_mode_bit_o      <= 1'b0;
            port1_backpressure_bit_o <= 1'b0;
            pause_tx_en_o            <= 1'b0;
            pause_rx_en_o            <= 1'b0;
        end
        // running: the load fires once, then registers follow next
        else
        begin
            load_pending_reg         <= 1'b0;
            basic_ctrl_reg           <= basic_ctrl_next;
            autoneg_advert_reg       <= autoneg_advert_next;
            mode_select_reg          <= mode_select_next;
            manual_pause_reg         <= manual_pause_next;
            rdata_o                  <= rdata_next;
            rate_select_low_bit_o    <= basic_ctrl_reg[`BIT_RATE_SEL];
            halffull_mode_bit_o      <= basic_ctrl_reg[`BIT_HALFFULL];
            port1_backpressure_bit_o <= manual_pause_reg[`BIT_BP_EN];
            pause_tx_en_o            <= tx_res;
            pause_rx_en_o            <= rx_res;
        end
    end

endmodule // port1_strap_defaults

/* sim/strap_board_model.sv */
/* board side of the port 1 loader: strap resistor levels.
   assumes: the setting is held steady across reset release. */
`timescale 1ns/1ps

module strap_board_model
(
    input  wire [5:0] cfg_i,  // {autoneg,speed,duplex,backpressure,pause,manual}
    output wire [5:0] strap_o // levels seen on the loader's strap inputs
);
    // resistors are static levels; only the loader decides when they count
    assign strap_o = cfg_i;
endmodule // strap_board_model

/* sim/port1_strap_defaults_sva.sv */
/* checker for the port 1 strap default loader.
   assumes: bound inside port1_strap_defaults; one clock, async reset. */
`timescale 1ns/1ps

module port1_strap_defaults_sva
(
    input wire        clk_i, rst_n_i, speed_default_i, duplex_default_i,
    input wire        autoneg_default_i, port1_backpressure_default_input_i,
    input wire        port1_pause_default_input_i, an_pause_tx_i,
    input wire        port1_manual_pause_select_input_i, an_pause_rx_i,
    input wire [3:0]  addr_i,
    input wire [15:0] wdata_i,
    input wire        wr_i, rd_i,
    input wire [15:0] rdata_o,
    input wire        rate_select_low_bit_o, halffull_mode_bit_o,
    input wire        port1_backpressure_bit_o, pause_tx_en_o, pause_rx_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    reg  [1:0] ph;              // edges since reset release, saturating
    wire       ld = (ph == 2'h2); // edge where loaded defaults first show
    // count edges after release so the load edge can be found
    always @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i) ph <= 2'h0;
        else if (ph != 2'h3) ph <= ph + 2'h1;
    sequence s_wr_man;
        wr_i && addr_i == 4'h3 && ph != 2'h0;
    endsequence
    property p_rate; ld |-> rate_select_low_bit_o == $past(speed_default_i, 2)
        && halffull_mode_bit_o == $past(duplex_default_i, 2); endproperty
    a_rate: assert property (p_rate) else $error("speed/duplex default");
    property p_bp; ld |-> port1_backpressure_bit_o ==
        $past(port1_backpressure_default_input_i, 2); endproperty
    a_bp: assert property (p_bp) else $error("backpressure default");
    property p_pause; ld && $past(port1_manual_pause_select_input_i, 2) |->
        pause_tx_en_o == $past(port1_pause_default_input_i, 2) &&
        pause_rx_en_o == $past(port1_pause_default_input_i, 2); endproperty
    a_pause: assert property (p_pause) else $error("pause default");
    property p_auto; ld && !$past(port1_manual_pause_select_input_i, 2) |->
        pause_tx_en_o == $past(an_pause_tx_i) &&
        pause_rx_en_o == $past(an_pause_rx_i); endproperty
    a_auto: assert property (p_auto) else $error("negotiated pause");
    property p_idle; !$past(rd_i) |-> rdata_o == 16'h0000; endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_hold; ph == 2'h3 && ($changed(rate_select_low_bit_o) ||
        $changed(halffull_mode_bit_o) || $changed(port1_backpressure_bit_o))
        |-> $past(wr_i, 2); endproperty
    a_hold: assert property (p_hold) else $error("output moved unwritten");
    property p_man; s_wr_man |-> ##2 port1_backpressure_bit_o ==
        $past(wdata_i[3], 2) && (!$past(wdata_i[2], 2) ||
        pause_tx_en_o == $past(wdata_i[1], 2)); endproperty
    a_man: assert property (p_man) else $error("manual pause write");
    property p_rdctl; rd_i && addr_i == 4'h0 |=> rdata_o[13] ==
        rate_select_low_bit_o && rdata_o[8] == halffull_mode_bit_o; endproperty
    a_rdctl: assert property (p_rdctl) else $error("control read");
endmodule // port1_strap_defaults_sva

/* sim/port1_strap_defaults_test.sv */
/* self-checking bench for the port 1 strap default loader.
   assumes: design, board model and checker compiled before it. */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end

bind port1_strap_defaults port1_strap_defaults_sva chk (.*);

module port1_strap_defaults_test;
    reg         clk_i, rst_n_i, wr_i, rd_i, an_tx, an_rx;
    reg         an, sp, du, bq, pa, mn;   // straps of the current setting
    reg  [5:0]  cfg;                      // setting handed to the board
    reg  [5:0]  cv [0:4] = '{6'h00, 6'h0F, 6'h13, 6'h1A, 6'h3C};
    reg  [3:0]  addr_i;
    reg  [15:0] wdata_i;
    wire [15:0] rdata_o;
    wire [5:0]  st;
    wire        rate, dup, bp, tx, rx;
    int         failures = 0, cmp_count = 0, i;
    strap_board_model board (.cfg_i(cfg), .strap_o(st));
    port1_strap_defaults DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .speed_default_i(st[4]), .duplex_default_i(st[3]),
        .autoneg_default_i(st[5]), .port1_backpressure_default_input_i(st[2]),
        .port1_pause_default_input_i(st[1]),
        .port1_manual_pause_select_input_i(st[0]), .an_pause_tx_i(an_tx),
        .an_pause_rx_i(an_rx), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .rate_select_low_bit_o(rate),
        .halffull_mode_bit_o(dup), .port1_backpressure_bit_o(bp),
        .pause_tx_en_o(tx), .pause_rx_en_o(rx));
    initial begin clk_i = 1'b0; forever #5 clk_i = ~clk_i; end
    // one-cycle write, then one-cycle read with data checked a cycle later
    task wr(input [3:0] a, input [15:0] v);
        @(posedge clk_i); addr_i <= a; wdata_i <= v; wr_i <= 1'b1;
        @(posedge clk_i); wr_i <= 1'b0;
    endtask
    task rd(input [3:0] a, input [15:0] e);
        @(posedge clk_i); addr_i <= a; rd_i <= 1'b1;
        @(posedge clk_i); rd_i <= 1'b0;
        #1 `CHK(rdata_o, e)
    endtask
    task outs(input [4:0] e); #1 `CHK({rate, dup, bp, tx, rx}, e) endtask
    task results;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin #50000; failures++; results; end
    initial
    begin
        rst_n_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; an_tx = 1'b1; an_rx = 1'b0;
        cfg = 6'h00; addr_i = 4'h0; wdata_i = 16'h0000;
        for (i = 0; i < 5; i++)
        begin
            rst_n_i <= 1'b0; cfg <= cv[i]; {an, sp, du, bq, pa, mn} = cv[i];
            repeat (5) @(posedge clk_i);
            rst_n_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            outs({sp, du, bq, mn ? pa : an_tx, mn ? pa : an_rx});
            cfg <= ~cv[i]; // later strap moves must be ignored
            rd(4'h0, {2'h0, sp, an, 3'h0, du, 8'h00});
            rd(4'h1, {5'h00, ~mn, 3'h3, an | (~sp & du), an | ~sp, 5'h01});
            rd(4'h2, {8'h00, an ? 3'h7 : {1'b0, sp, du}, 5'h00});
            rd(4'h3, {12'h000, bq, mn, pa, pa});
            outs({sp, du, bq, mn ? pa : an_tx, mn ? pa : an_rx});
            $display("test straps %h done", cv[i]);
        end
        wr(4'h3, 16'hFFFD); @(posedge clk_i); outs(5'h1D);
        rd(4'h3, 16'h000D);
        wr(4'h4, 16'hFFFF); rd(4'h4, 16'h0001);
        wr(4'h0, 16'h0000); @(posedge clk_i); outs(5'h05);
        wr(4'h3, 16'h0000); @(posedge clk_i); outs(5'h02);
        rd(4'hF, 16'h0000);
        $display("test register writes done");
        results;
    end
endmodule // port1_strap_defaults_test
